// ===== logic/ifd_consts.vh
// constants for the instruction fetch and decode block
`ifndef IFD_CONSTS_VH
`define IFD_CONSTS_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define IFD_OFS_CTRL    4'h0
`define IFD_OFS_STATUS  4'h4
`define IFD_OFS_FIELDS  4'h8
`define IFD_OFS_DECODE  4'hC
`define IFD_CTRL_RST    2'h0
`define IFD_CTRL_RUN    0
`define IFD_CTRL_ROM    1
// ---------------------------------------------------------------
// axi responses
// ---------------------------------------------------------------
`define IFD_RESP_OKAY   2'h0
`define IFD_RESP_SLVERR 2'h2
// ---------------------------------------------------------------
// instruction fields
// ---------------------------------------------------------------
`define IFD_OP_HI       15
`define IFD_OP_LO       12
`define IFD_SUB_HI      11
`define IFD_SUB_LO      8
`define IFD_MODE_BIT    11
`define IFD_UNSIGNED_DISPLACEMENT_HI     9
`define IFD_SIGNED_DISPLACEMENT_MSB   7
`define IFD_IDX_HI      9
`define IFD_IDX_LO      8
`define IFD_IOREG_HI    10
`define IFD_IOREG_LO    8
`define IFD_IOMODE_HI   7
`define IFD_IOMODE_LO   6
`define IFD_SKIP_REV    8
// ---------------------------------------------------------------
// main op codes (top nibble)
// ---------------------------------------------------------------
`define IFD_OP_GEN      4'h0
`define IFD_OP_SKIP     4'h2
`define IFD_OP_RESET_BIT     4'h3
`define IFD_OP_LOAD_BYTE     4'h8
`define IFD_OP_STORE_BYTE     4'h9
`define IFD_OP_TEST_BIT     4'hA
`define IFD_OP_SET_BIT     4'hB
`define IFD_OP_LDR      4'hC
`define IFD_OP_STR      4'hD
`define IFD_OP_CMR      4'hE
`define IFD_OP_MULTI    4'hF
`define IFD_MEMREF_MASK 16'hFFFA
// ---------------------------------------------------------------
// sub-class codes (bits 8-11 when op is general)
// ---------------------------------------------------------------
`define IFD_SUB_SPEC    4'h0
`define IFD_SUB_ROL     4'h1
`define IFD_SUB_SRLA    4'h2
`define IFD_SUB_SRCC    4'h3
`define IFD_SUB_CTRL    4'h4
`define IFD_SUB_RCS     4'h5
`define IFD_SUB_RCD     4'h6
`define IFD_SUB_RCO     4'h7
`define IFD_SG_WAIT     4'h0
`define IFD_SG_MPY      4'h8
`define IFD_SG_DIV      4'hA
`endif

// ===== logic/ifd_fetch_decode.v
// instruction fetch timing and general decode with axi4-lite registers
//
// Contract
// - a memory start clock is raised as every instruction cycle begins.
// - rom fetch of a non memory-reference word starts the next fetch after phase two.
// - otherwise the next memory start clock comes only after phase four.
// - the memory data word is copied into the instruction register during fetch.
// - the top four bits of the instruction register pick the main class.
// - bits 8 to 11 are decoded into the separate sub-class enables.
// - the special general enable covers wait, multiply and divide.
// - one enable routes the instruction register onto the alu function bus.
// - bits 0 to 9 form the unsigned base-relative displacement.
// - the indexed format top nibble picks the operation and bit 11 picks base or direct.
// - skips use high bytes 20 to 2F, even forward, odd reverse with signed low byte.
// - the program-relative displacement is sign extended up through bit 15.
// - bits 8 and 9 select one of the three index registers.
// - io instructions take the register from bits 8 to 10 and the mode from bits 6 and 7.
`include "ifd_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module ifd_fetch_decode (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    input  wire [3:0]  s_axi_awaddr_i,
    input  wire        s_axi_awvalid_i,
    output wire        s_axi_awready_o,
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output wire        s_axi_wready_o,
    output reg  [1:0]  s_axi_bresp_o,
    output reg         s_axi_bvalid_o,
    input  wire        s_axi_bready_i,
    input  wire [3:0]  s_axi_araddr_i,
    input  wire        s_axi_arvalid_i,
    output wire        s_axi_arready_o,
    output reg  [31:0] s_axi_rdata_o,
    output reg  [1:0]  s_axi_rresp_o,
    output reg         s_axi_rvalid_o,
    input  wire        s_axi_rready_i,
    input  wire [15:0] mem_data_i,
    output reg         mem_start_o,
    output wire        timing_phase_two_o,
    output wire        timing_phase_four_o,
    output reg  [15:0] instr_o,
    output reg  [15:0] main_class_o,
    output reg         special_general_enable_o,
    output reg         reg_operate_literal_enable_o,
    output reg         shift_right_logic_arith_enable_o,
    output reg         shift_right_circular_enable_o,
    output reg         control_instr_enable_o,
    output reg         reg_change_source_enable_o,
    output reg         reg_change_dest_enable_o,
    output reg         reg_change_operate_enable_o,
    output reg         general_class_o,
    output reg         execute_decode_o,
    output reg         reg_operate_group_decode_o,
    output reg         alu_bus_from_instr_select_o,
    output reg         hw_multiply_o,
    output reg  [9:0]  unsigned_displacement_o,
    output reg  [15:0] signed_displacement_o,
    output reg  [8:0]  mem_op_o,
    output reg         base_mode_o,
    output reg         skip_o,
    output reg         skip_reverse_o,
    output reg  [2:0]  index_select_o,
    output reg  [2:0]  io_reg_select_o,
    output reg  [3:0]  io_mode_o
);

    // ---------------------------------------------------------------
    // timing phases
    // ---------------------------------------------------------------
    localparam [4:0] PH_IDLE = 5'h01;
    localparam [4:0] PH_1    = 5'h02;
    localparam [4:0] PH_2    = 5'h04;
    localparam [4:0] PH_3    = 5'h08;
    localparam [4:0] PH_4    = 5'h10;

    reg  [4:0]  phase_r;
    reg  [4:0]  phase_nxt;
    reg  [1:0]  ctrl_r;
    reg         overlap_r;
    wire        run      = ctrl_r[`IFD_CTRL_RUN];
    wire        rom_src  = ctrl_r[`IFD_CTRL_ROM];
    wire [3:0]  word_op  = mem_data_i[`IFD_OP_HI:`IFD_OP_LO];
    wire [3:0]  word_sub = mem_data_i[`IFD_SUB_HI:`IFD_SUB_LO];
    wire        load_ir  = (phase_r == PH_1);
    // mask bit n set when top nibble n is a memory-reference op
    wire [15:0] memref_map = `IFD_MEMREF_MASK;
    wire        memref   = memref_map[word_op];
    wire        start_nxt;

    assign timing_phase_two_o  = (phase_r == PH_2);
    assign timing_phase_four_o = (phase_r == PH_4);

    // phase sequencing; the overlap choice is taken from the fetched word
    always @* begin
        phase_nxt = PH_IDLE;
        case (phase_r)
            PH_IDLE: phase_nxt = run ? PH_1 : PH_IDLE;
            PH_1:    phase_nxt = PH_2;
            PH_2:    phase_nxt = (overlap_r && run) ? PH_1 :
                                 (overlap_r ? PH_IDLE : PH_3);
            PH_3:    phase_nxt = PH_4;
            PH_4:    phase_nxt = run ? PH_1 : PH_IDLE;
            default: phase_nxt = PH_IDLE;
        endcase
    end

    // every entry into phase one is the start of an instruction cycle
    assign start_nxt = (phase_nxt == PH_1) && (phase_r != PH_1);

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            phase_r     <= PH_IDLE;
            mem_start_o <= 1'b0;
            overlap_r   <= 1'b0;
        end else begin
            phase_r     <= phase_nxt;
            mem_start_o <= start_nxt;
            if (load_ir) begin
                // rom and not memory reference lets the fetch overlap
                overlap_r <= rom_src && !memref;
            end
        end
    end

    // ---------------------------------------------------------------
    // instruction register and latched decodes
    // ---------------------------------------------------------------
    // decodes are latched with the word so they cannot glitch mid-instruction
    wire gen_w = (word_op == `IFD_OP_GEN);
    wire [3:0] sg_w = mem_data_i[7:4];

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            instr_o                          <= 16'h0000;
            main_class_o                     <= 16'h0000;
            special_general_enable_o         <= 1'b0;
            reg_operate_literal_enable_o     <= 1'b0;
            shift_right_logic_arith_enable_o <= 1'b0;
            shift_right_circular_enable_o    <= 1'b0;
            control_instr_enable_o           <= 1'b0;
            reg_change_source_enable_o       <= 1'b0;
            reg_change_dest_enable_o         <= 1'b0;
            reg_change_operate_enable_o      <= 1'b0;
            general_class_o                  <= 1'b0;
            execute_decode_o                 <= 1'b0;
            reg_operate_group_decode_o       <= 1'b0;
            alu_bus_from_instr_select_o      <= 1'b0;
            hw_multiply_o                    <= 1'b0;
            unsigned_displacement_o          <= 10'h000;
            signed_displacement_o            <= 16'h0000;
            mem_op_o                         <= 9'h000;
            base_mode_o                      <= 1'b0;
            skip_o                           <= 1'b0;
            skip_reverse_o                   <= 1'b0;
            index_select_o                   <= 3'h0;
            io_reg_select_o                  <= 3'h0;
            io_mode_o                        <= 4'h0;
        end else if (load_ir) begin
            instr_o <= mem_data_i;
            main_class_o <= 16'h0001 << word_op;
            // sub-class enables only exist inside the general class
            special_general_enable_o <= gen_w && (word_sub == `IFD_SUB_SPEC)
                && ((sg_w == `IFD_SG_WAIT) || (sg_w == `IFD_SG_MPY)
                || (sg_w == `IFD_SG_DIV));
            reg_operate_literal_enable_o <= gen_w && (word_sub == `IFD_SUB_ROL);
            shift_right_logic_arith_enable_o <= gen_w && (word_sub == `IFD_SUB_SRLA);
            shift_right_circular_enable_o <= gen_w && (word_sub == `IFD_SUB_SRCC);
            control_instr_enable_o <= gen_w && (word_sub == `IFD_SUB_CTRL);
            reg_change_source_enable_o <= gen_w && (word_sub == `IFD_SUB_RCS);
            reg_change_dest_enable_o <= gen_w && (word_sub == `IFD_SUB_RCD);
            reg_change_operate_enable_o <= gen_w && (word_sub == `IFD_SUB_RCO);
            general_class_o <= gen_w;
            execute_decode_o <= gen_w && (word_sub == `IFD_SUB_RCS)
                && mem_data_i[4] && (mem_data_i[3:0] == 4'h0);
            reg_operate_group_decode_o <= gen_w && ((word_sub == `IFD_SUB_ROL)
                || (word_sub == `IFD_SUB_RCO));
            // literal and control words carry their operand in the word itself
            alu_bus_from_instr_select_o <= gen_w && ((word_sub == `IFD_SUB_ROL)
                || (word_sub == `IFD_SUB_CTRL));
            hw_multiply_o <= gen_w && (word_sub == `IFD_SUB_SPEC)
                && (sg_w == `IFD_SG_MPY);
            unsigned_displacement_o <= mem_data_i[`IFD_UNSIGNED_DISPLACEMENT_HI:0];
            signed_displacement_o <= {{8{mem_data_i[`IFD_SIGNED_DISPLACEMENT_MSB]}},
                mem_data_i[`IFD_SIGNED_DISPLACEMENT_MSB:0]};
            // one-hot indexed op: ldr str cmr load_byte store_byte set_bit reset_bit test_bit multi
            mem_op_o <= {word_op == `IFD_OP_MULTI, word_op == `IFD_OP_TEST_BIT,
                word_op == `IFD_OP_RESET_BIT, word_op == `IFD_OP_SET_BIT,
                word_op == `IFD_OP_STORE_BYTE, word_op == `IFD_OP_LOAD_BYTE,
                word_op == `IFD_OP_CMR, word_op == `IFD_OP_STR,
                word_op == `IFD_OP_LDR};
            base_mode_o <= memref && mem_data_i[`IFD_MODE_BIT];
            skip_o <= (word_op == `IFD_OP_SKIP);
            skip_reverse_o <= (word_op == `IFD_OP_SKIP)
                && mem_data_i[`IFD_SKIP_REV];
            // code 3 selects no index register
            index_select_o <= (3'h1 << mem_data_i[`IFD_IDX_HI:`IFD_IDX_LO]);
            io_reg_select_o <= mem_data_i[`IFD_IOREG_HI:`IFD_IOREG_LO];
            io_mode_o <= 4'h1 << mem_data_i[`IFD_IOMODE_HI:`IFD_IOMODE_LO];
        end
    end

    // ---------------------------------------------------------------
    // axi4-lite write channel
    // ---------------------------------------------------------------
    reg        aw_held_r;
    reg        w_held_r;
    reg [3:0]  aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;

    // one write at a time: address and data are each parked until both exist
    assign s_axi_awready_o = !aw_held_r && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_held_r && !s_axi_bvalid_o;

    wire       aw_take = s_axi_awvalid_i && s_axi_awready_o;
    wire       w_take  = s_axi_wvalid_i && s_axi_wready_o;
    wire       aw_have = aw_held_r || aw_take;
    wire       w_have  = w_held_r || w_take;
    wire       wr_go   = aw_have && w_have;
    wire [3:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr_i;
    wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata_i;
    wire [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb_i;

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            aw_held_r      <= 1'b0;
            w_held_r       <= 1'b0;
            aw_addr_r      <= 4'h0;
            w_data_r       <= 32'h0000_0000;
            w_strb_r       <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `IFD_RESP_OKAY;
            ctrl_r         <= `IFD_CTRL_RST;
        end else begin
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr_i;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata_i;
                w_strb_r <= s_axi_wstrb_i;
            end
            aw_held_r <= aw_have && !wr_go;
            w_held_r  <= w_have && !wr_go;
            if (wr_go) begin
                s_axi_bvalid_o <= 1'b1;
                if (wr_addr == `IFD_OFS_CTRL) begin
                    s_axi_bresp_o <= `IFD_RESP_OKAY;
                    if (wr_strb[0]) begin
                        ctrl_r <= wr_data[1:0];
                    end
                end else if (wr_addr == `IFD_OFS_STATUS || wr_addr == `IFD_OFS_FIELDS
                             || wr_addr == `IFD_OFS_DECODE) begin
                    s_axi_bresp_o <= `IFD_RESP_OKAY;   // read-only, write ignored
                end else begin
                    s_axi_bresp_o <= `IFD_RESP_SLVERR;
                end
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // axi4-lite read channel
    // ---------------------------------------------------------------
    assign s_axi_arready_o = !s_axi_rvalid_o;

    // read mux of live block state
    reg [31:0] rd_mux;
    reg        rd_ok;
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        case (s_axi_araddr_i)
            `IFD_OFS_CTRL:   rd_mux = {30'h0000_0000, ctrl_r};
            `IFD_OFS_STATUS: rd_mux = {11'h000, mem_start_o, phase_r[4:1], instr_o};
            `IFD_OFS_FIELDS: rd_mux = {base_mode_o, skip_reverse_o, io_mode_o,
                                       io_reg_select_o, index_select_o, 4'h0,
                                       signed_displacement_o};
            `IFD_OFS_DECODE: rd_mux = {2'h0, skip_o, mem_op_o, hw_multiply_o,
                                       alu_bus_from_instr_select_o,
                                       reg_operate_group_decode_o, execute_decode_o,
                                       general_class_o, reg_change_operate_enable_o,
                                       reg_change_dest_enable_o,
                                       reg_change_source_enable_o,
                                       control_instr_enable_o,
                                       shift_right_circular_enable_o,
                                       shift_right_logic_arith_enable_o,
                                       reg_operate_literal_enable_o,
                                       special_general_enable_o,
                                       3'h0, unsigned_displacement_o[3:0]};
            default:         rd_ok  = 1'b0;
        endcase
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= `IFD_RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_mux;
            s_axi_rresp_o  <= rd_ok ? `IFD_RESP_OKAY : `IFD_RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

endmodule // ifd_fetch_decode

`default_nettype wire

// ===== test/ifd_fetch_decode_properties.sv
// concurrent checks on the fetch and decode ports
`timescale 1ns/100ps
`default_nettype none
module ifd_fetch_decode_checker (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic [15:0] mem_data_i,
    input wire logic        mem_start_o,
    input wire logic        timing_phase_two_o,
    input wire logic [15:0] instr_o,
    input wire logic [15:0] main_class_o,
    input wire logic [9:0]  unsigned_displacement_o,
    input wire logic [15:0] signed_displacement_o,
    input wire logic        base_mode_o,
    input wire logic        skip_o,
    input wire logic        skip_reverse_o,
    input wire logic [2:0]  index_select_o,
    input wire logic [2:0]  io_reg_select_o,
    input wire logic [3:0]  io_mode_o
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // decodes are only meaningful once a word has been loaded, so phase two gates them
    wire logic [3:0] op = instr_o[15:12];
    a_start_phase: assert property (mem_start_o |=> timing_phase_two_o && !mem_start_o)
        else $error("start pulse not followed by phase two");
    a_memref_slow: assert property (timing_phase_two_o && op != 4'h0 && op != 4'h2
        |=> !mem_start_o ##1 !mem_start_o) else $error("memory reference fetch overlapped");
    a_instr_load: assert property (mem_start_o |=> instr_o == $past(mem_data_i))
        else $error("instruction register not loaded from memory data");
    a_instr_hold: assert property (!mem_start_o |=> $stable(instr_o))
        else $error("instruction register changed outside fetch");
    a_class_onehot: assert property (timing_phase_two_o |-> main_class_o == (16'h1 << op))
        else $error("main class decode wrong");
    a_unsigned_displacement_fields: assert property (timing_phase_two_o |->
        unsigned_displacement_o == instr_o[9:0] &&
        signed_displacement_o == {{8{instr_o[7]}}, instr_o[7:0]}) else $error("displacement wrong");
    a_base_mode: assert property (timing_phase_two_o |->
        base_mode_o == (instr_o[11] && op != 4'h0 && op != 4'h2)) else $error("base mode wrong");
    a_skip_dir: assert property (timing_phase_two_o |-> skip_o == (op == 4'h2) &&
        skip_reverse_o == (op == 4'h2 && instr_o[8])) else $error("skip decode wrong");
    a_index_sel: assert property (timing_phase_two_o |-> index_select_o ==
        ((instr_o[9:8] == 2'h3) ? 3'h0 : (3'h1 << instr_o[9:8]))) else $error("index select wrong");
    a_io_fields: assert property (timing_phase_two_o |-> io_reg_select_o == instr_o[10:8] &&
        io_mode_o == (4'h1 << instr_o[7:6])) else $error("io fields wrong");
    c_overlap: cover property (mem_start_o ##2 mem_start_o);
    c_full: cover property (mem_start_o ##4 mem_start_o);
    c_reverse: cover property (timing_phase_two_o && skip_reverse_o);
endmodule // ifd_fetch_decode_checker
bind ifd_fetch_decode ifd_fetch_decode_checker u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .mem_data_i(mem_data_i), .mem_start_o(mem_start_o),
    .timing_phase_two_o(timing_phase_two_o), .instr_o(instr_o), .main_class_o(main_class_o),
    .unsigned_displacement_o(unsigned_displacement_o),
    .signed_displacement_o(signed_displacement_o), .base_mode_o(base_mode_o), .skip_o(skip_o),
    .skip_reverse_o(skip_reverse_o), .index_select_o(index_select_o),
    .io_reg_select_o(io_reg_select_o), .io_mode_o(io_mode_o));
`default_nettype wire

// ===== test/ifd_mem_model.sv
// memory data register model feeding the fetch path
`timescale 1ns/100ps
`default_nettype none
module ifd_mem_model (
    input  wire logic        mem_start_i,
    input  wire logic [15:0] word_i,
    output var  logic [15:0] mem_data_o
);
    // word only valid in the access cycle; inverted otherwise so a mistimed sample shows
    always_comb mem_data_o = mem_start_i ? word_i : ~word_i;
endmodule // ifd_mem_model
`default_nettype wire

// ===== test/instruction_fetch_decode_tb.sv
// self-checking bench for fetch timing, decode and register access
`timescale 1ns/100ps
`default_nettype none
module instruction_fetch_decode_tb;
    logic clk_i = 0, sys_rst_i = 1;
    logic [3:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    wire logic awready, wready, bvalid, arready, rvalid, mem_start_o;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] mem_data, instr_o, main_class_o, sdisp;
    wire logic [9:0] udisp;
    wire logic [8:0] mem_op;
    wire logic [2:0] idx_sel, io_reg;
    wire logic [3:0] io_mode;
    wire logic ph2, ph4, sg, rol, srla, srcc, ctl, rcs, rcd, rco, gen, execute_decode, reg_operate_group_decode, alu_sel, hw_multiply;
    wire logic base_m, skp, skp_rev;
    logic [15:0] prog [0:7] = '{16'h0000, 16'h0080, 16'h21F0, 16'hCB83,
                                16'h0153, 16'h0412, 16'h2E00, 16'hF5C1};
    logic [2:0] pidx = 0;
    logic restart = 0;
    int n_errors = 0, n_compared = 0;
    // ----------------------------------------
    // clock, reset, design and memory
    // ----------------------------------------
    initial forever #4 clk_i = ~clk_i;
    ifd_fetch_decode u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .mem_data_i(mem_data), .mem_start_o(mem_start_o),
        .timing_phase_two_o(ph2), .timing_phase_four_o(ph4), .instr_o(instr_o),
        .main_class_o(main_class_o), .special_general_enable_o(sg),
        .reg_operate_literal_enable_o(rol), .shift_right_logic_arith_enable_o(srla),
        .shift_right_circular_enable_o(srcc), .control_instr_enable_o(ctl),
        .reg_change_source_enable_o(rcs), .reg_change_dest_enable_o(rcd),
        .reg_change_operate_enable_o(rco), .general_class_o(gen), .execute_decode_o(execute_decode),
        .reg_operate_group_decode_o(reg_operate_group_decode), .alu_bus_from_instr_select_o(alu_sel),
        .hw_multiply_o(hw_multiply), .unsigned_displacement_o(udisp), .signed_displacement_o(sdisp),
        .mem_op_o(mem_op), .base_mode_o(base_m), .skip_o(skp), .skip_reverse_o(skp_rev),
        .index_select_o(idx_sel), .io_reg_select_o(io_reg), .io_mode_o(io_mode));
    ifd_mem_model u_mem (.mem_start_i(mem_start_o), .word_i(prog[pidx]), .mem_data_o(mem_data));
    // next program word is offered once the current fetch has been sampled
    always @(posedge clk_i) begin
        if (restart) pidx <= 3'h0;
        else if (mem_start_o) pidx <= pidx + 3'h1;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp);
        int t;
        @(posedge clk_i);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        t = 0;
        // each half drops on its own handshake; bready stays up until the answer
        do begin
            @(posedge clk_i);
            t++;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid && t < 100);
        bready <= 0;
        check({bvalid, bresp}, {1'b1, exp});
    endtask
    task axi_rd(input logic [3:0] a, input logic [31:0] expd, input logic [1:0] exp);
        int t;
        @(posedge clk_i);
        araddr <= a; arvalid <= 1; rready <= 1;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid && t < 100);
        rready <= 0;
        check({rvalid, rresp}, {1'b1, exp});
        check(rdata, expd);
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #(8 * 20000);
        n_errors++;
        tally_and_finish;
    end
    initial begin
        logic [15:0] w;
        logic [3:0] op;
        logic [7:0] e;
        int gap;
        int n;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 0;
        axi_rd(4'h0, 32'h0, 2'h0);
        axi_rd(4'h2, 32'h0, 2'h2);
        axi_wr(4'h6, 32'h1, 2'h2);
        axi_wr(4'h8, 32'hFFFF, 2'h0);
        for (int rom = 0; rom < 2; rom++) begin
            restart <= 1;
            axi_wr(4'h0, {30'h0, rom[0], 1'b1}, 2'h0);
            // the first fetch is already under way here, so no read may wait before it
            restart <= 0;
            for (int i = 0; i < 8; i++) begin
                gap = 0;
                #1;
                while (!mem_start_o && gap < 50) begin
                    @(posedge clk_i); #1; gap++;
                end
                w = prog[i];
                op = w[15:12];
                // overlapped fetch starts again right after phase two
                if (i > 0) check(gap, (rom && (prog[i-1][15:12] == 4'h0 || prog[i-1][15:12] == 4'h2)) ? 1 : 3);
                @(posedge clk_i); #1;
                check(ph2, 1'b1);
                check(instr_o, w);
                check(main_class_o, 16'h1 << op);
                e = (op == 4'h0) ? (8'h01 << w[11:8]) : 8'h0;
                check({rco, rcd, rcs, ctl, srcc, srla, rol}, e[7:1]);
                check(sg, op == 4'h0 && w[11:8] == 4'h0 && (w[7:4] == 4'h0 || w[7:4] == 4'h8 || w[7:4] == 4'hA));
                check(hw_multiply, w[15:4] == 12'h008);
                check(alu_sel, op == 4'h0 && (w[11:8] == 4'h1 || w[11:8] == 4'h4));
                check({gen, reg_operate_group_decode, execute_decode}, {op == 4'h0, op == 4'h0 && (w[11:8] == 4'h1 || w[11:8] == 4'h7), w[15:0] == 16'h0510});
                check(udisp, w[9:0]);
                check(sdisp, {{8{w[7]}}, w[7:0]});
                check(base_m, w[11] && op != 4'h0 && op != 4'h2);
                check(mem_op, op == 4'hC ? 9'h001 : op == 4'hD ? 9'h002 : op == 4'hE ? 9'h004 : op == 4'h8 ? 9'h008 : op == 4'h9 ? 9'h010 : op == 4'hB ? 9'h020 : op == 4'h3 ? 9'h040 : op == 4'hA ? 9'h080 : op == 4'hF ? 9'h100 : 9'h000);
                check({skp, skp_rev}, {op == 4'h2, op == 4'h2 && w[8]});
                check(idx_sel, w[9:8] == 2'h3 ? 3'h0 : 3'h1 << w[9:8]);
                check({io_reg, io_mode}, {w[10:8], 4'h1 << w[7:6]});
            end
            axi_rd(4'h0, {30'h0, rom[0], 1'b1}, 2'h0);
            axi_wr(4'h0, 32'h0, 2'h0);
            repeat (8) @(posedge clk_i);
            n = 0;
            // stopped: the sequencer must stay idle
            repeat (12) begin
                @(posedge clk_i); #1;
                if (mem_start_o) n++;
            end
            check(n, 0);
        end
        tally_and_finish;
    end
endmodule // instruction_fetch_decode_tb
`default_nettype wire
